/* rtl/adc_seq_pkg.sv */
package adc_seq_pkg;
  localparam int RESULT_BITS = 12;
  localparam int CTRL_BITS = 8;
  localparam int ADDR_MSB = 5;
  localparam int ADDR_LSB = 3;
  localparam int FRAME_LEN = 16;
  localparam logic [3:0] POS_IDLE = 4'hf;
  localparam logic [3:0] POS_HOLD = 4'h3;
  localparam logic [3:0] POS_FIRST_BIT = 4'h4;
  localparam logic [3:0] RISE_LAST_CTRL = 4'h7;
  localparam logic [3:0] RISE_RESET = 4'h0;
  localparam logic [1:0] CHAN_DEFAULT = 2'h0;
  localparam logic [3:0] INPUT_SEL_DEFAULT = 4'h1;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [11:0] RESULT_RESET = 12'h000;

  typedef struct packed {
    logic track;
    logic power_down;
    logic [1:0] channel;
  } conv_status_type;

  localparam conv_status_type STATUS_RESET = '{track: 1'b0, power_down: 1'b1, channel: CHAN_DEFAULT};
endpackage

/* rtl/quad_channel_adc_serial_sequencer.sv */
`timescale 1ns/1ns
// Functional notes
// RQ1: first three serial clock cycles of each conversion are track mode.
// RQ2: cycles four to sixteen hold the sample, convert and shift out.
// RQ3: result leaves most significant bit first, first bit on cycle five.
// RQ4: host frames with select low and gives whole multiples of 16 rising edges.
// RQ5: output floats while select high, driven while select low.
// RQ6: power down while select high and between conversions in a frame.
// RQ7: track again after rising edge 16N, hold again on falling edge 16N+4.
// RQ8: select high gates the internal serial clock off.
// RQ9: clock parked low: select fall makes the first internal falling edge.
// RQ10: clock parked high: track starts on first real falling edge.
// RQ11: control word captured on first eight rising edges of each conversion.
// RQ12: host sends the channel for the next conversion, not the current.
// RQ13: select and clock falling together: next rising edge is first capture.
// RQ14: no warm-up needed; first conversion after power-up samples input one.
// RQ15: control bits 7 to 6 and 2 to 0 are ignored.
// RQ16: control bits 5 to 3 are the channel address for the next conversion.
// RQ17: address top bit ignored; low two bits pick input one to four.
// RQ18: result is 12-bit straight binary.
// RQ19: conversions of 16 cycles repeat while select stays low.
// RQ20: output low for first four cycles; bits change on falling edges.
// RQ21: channel held until a full new word arrives; input one at power-up.
module quad_channel_adc_serial_sequencer (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic serial_clock,
  input wire logic frame_select_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_en,
  input wire logic [adc_seq_pkg::RESULT_BITS-1:0] conv_result,
  output logic [3:0] input_select,
  output logic track_mode,
  output logic power_down,
  output logic sample_strobe
);
  // internal serial clock, forced high while deselected
  logic link_clk_int;
  logic [3:0] pos_reg;
  logic [3:0] pos_next;
  logic [3:0] rise_pos_reg;
  logic [adc_seq_pkg::RESULT_BITS-1:0] shift_reg;
  logic out_reg;
  logic track_link_reg;
  logic power_down_link_reg;
  logic hold_toggle_reg;
  logic [adc_seq_pkg::CTRL_BITS-1:0] ctrl_shift_reg;
  logic [adc_seq_pkg::CTRL_BITS-1:0] ctrl_word_next;
  logic [1:0] channel_reg;
  adc_seq_pkg::conv_status_type link_status;
  adc_seq_pkg::conv_status_type status_sync1_reg;
  adc_seq_pkg::conv_status_type status_sync2_reg;
  logic [2:0] hold_sync_reg;
  logic [adc_seq_pkg::RESULT_BITS-1:0] result_reg;
  logic [3:0] input_select_reg;
  logic track_mode_reg;
  logic power_down_reg;
  logic sample_strobe_reg;

  assign link_clk_int = serial_clock | frame_select_n; // RQ8 RQ9 RQ10
  assign pos_next = pos_reg + 4'h1;
  assign ctrl_word_next = {ctrl_shift_reg[adc_seq_pkg::CTRL_BITS-2:0], serial_in};

  // falling-edge position within a conversion, wraps every 16
  always_ff @(negedge link_clk_int or posedge frame_select_n) begin
    if (frame_select_n) begin
      pos_reg <= adc_seq_pkg::POS_IDLE; // RQ8
    end else begin
      pos_reg <= pos_next; // RQ7 RQ19
    end
  end

  // track and power-down phase
  always_ff @(negedge link_clk_int or posedge frame_select_n) begin
    if (frame_select_n) begin
      track_link_reg <= 1'b0;
      power_down_link_reg <= 1'b1; // RQ6
    end else begin
      track_link_reg <= (pos_next < adc_seq_pkg::POS_HOLD); // RQ1 RQ2 RQ7
      power_down_link_reg <= (pos_next == adc_seq_pkg::POS_IDLE); // RQ6
    end
  end

  // hold event toward the system side
  always_ff @(negedge link_clk_int or posedge rst) begin
    if (rst) begin
      hold_toggle_reg <= 1'b0;
    end else if (!frame_select_n && pos_next == adc_seq_pkg::POS_HOLD) begin
      hold_toggle_reg <= ~hold_toggle_reg; // RQ2 RQ7
    end
  end

  // result shifter, changes on falling edges
  always_ff @(negedge link_clk_int or posedge frame_select_n) begin
    if (frame_select_n) begin
      out_reg <= 1'b0;
      shift_reg <= adc_seq_pkg::RESULT_RESET;
    end else if (pos_next == adc_seq_pkg::POS_FIRST_BIT) begin
      out_reg <= result_reg[adc_seq_pkg::RESULT_BITS-1]; // RQ3 RQ18
      shift_reg <= {result_reg[adc_seq_pkg::RESULT_BITS-2:0], 1'b0};
    end else if (pos_next > adc_seq_pkg::POS_FIRST_BIT) begin
      out_reg <= shift_reg[adc_seq_pkg::RESULT_BITS-1]; // RQ3
      shift_reg <= {shift_reg[adc_seq_pkg::RESULT_BITS-2:0], 1'b0};
    end else begin
      out_reg <= 1'b0; // RQ20
      shift_reg <= shift_reg;
    end
  end

  assign serial_out = out_reg; // RQ20
  assign serial_out_en = ~frame_select_n; // RQ5

  // rising-edge position within a conversion
  always_ff @(posedge link_clk_int or posedge frame_select_n) begin
    if (frame_select_n) begin
      rise_pos_reg <= adc_seq_pkg::RISE_RESET; // RQ13
    end else begin
      rise_pos_reg <= rise_pos_reg + 4'h1;
    end
  end

  // control word capture
  always_ff @(posedge link_clk_int or posedge rst) begin
    if (rst) begin
      ctrl_shift_reg <= adc_seq_pkg::CTRL_RESET;
    end else if (!frame_select_n && rise_pos_reg <= adc_seq_pkg::RISE_LAST_CTRL) begin
      ctrl_shift_reg <= ctrl_word_next; // RQ11 RQ13
    end
  end

  // channel address for the next conversion
  always_ff @(posedge link_clk_int or posedge rst) begin
    if (rst) begin
      channel_reg <= adc_seq_pkg::CHAN_DEFAULT; // RQ14 RQ21
    end else if (!frame_select_n && rise_pos_reg == adc_seq_pkg::RISE_LAST_CTRL) begin
      channel_reg <= ctrl_word_next[adc_seq_pkg::ADDR_LSB+1:adc_seq_pkg::ADDR_LSB]; // RQ12 RQ15 RQ16 RQ17 RQ21
    end
  end

  assign link_status = '{track: track_link_reg, power_down: power_down_link_reg, channel: channel_reg};

  // level crossing into the system domain
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      status_sync1_reg <= adc_seq_pkg::STATUS_RESET;
      status_sync2_reg <= adc_seq_pkg::STATUS_RESET;
    end else begin
      status_sync1_reg <= link_status;
      status_sync2_reg <= status_sync1_reg;
    end
  end

  // hold event crossing and edge detect
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hold_sync_reg <= 3'h0;
    end else begin
      hold_sync_reg <= {hold_sync_reg[1:0], hold_toggle_reg};
    end
  end

  // result latched at hold start, stable until the next hold
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      result_reg <= adc_seq_pkg::RESULT_RESET;
      sample_strobe_reg <= 1'b0;
    end else begin
      sample_strobe_reg <= hold_sync_reg[2] ^ hold_sync_reg[1];
      if (hold_sync_reg[2] ^ hold_sync_reg[1]) begin
        result_reg <= conv_result; // RQ18
      end
    end
  end

  // system-side status outputs and one-hot input decode
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      input_select_reg <= adc_seq_pkg::INPUT_SEL_DEFAULT; // RQ14
      track_mode_reg <= 1'b0;
      power_down_reg <= 1'b1;
    end else begin
      input_select_reg <= 4'h1 << status_sync2_reg.channel; // RQ17
      track_mode_reg <= status_sync2_reg.track;
      power_down_reg <= status_sync2_reg.power_down; // RQ6
    end
  end

  assign input_select = input_select_reg;
  assign track_mode = track_mode_reg;
  assign power_down = power_down_reg;
  assign sample_strobe = sample_strobe_reg;
endmodule // quad_channel_adc_serial_sequencer

/* sim/adc_seq_monitor.sv */
`timescale 1ns/1ns
module adc_seq_monitor (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic serial_clock,
  input wire logic frame_select_n,
  input wire logic serial_out,
  input wire logic serial_out_en,
  input wire logic [adc_seq_pkg::RESULT_BITS-1:0] conv_result,
  input wire logic [3:0] input_select,
  input wire logic track_mode,
  input wire logic power_down,
  input wire logic sample_strobe
);
  // rising edges seen in the current conversion, wraps every 16
  logic [3:0] rise_cnt;
  always_ff @(posedge serial_clock or posedge frame_select_n) begin
    if (frame_select_n) rise_cnt <= 4'h0;
    else rise_cnt <= rise_cnt + 4'h1;
  end
  chk_enable_follows: assert property (@(posedge sys_clk) disable iff (rst) serial_out_en == !frame_select_n)
    else $error("output enable differs from select");
  chk_idle_power: assert property (@(posedge sys_clk) disable iff (rst) frame_select_n [*6] |-> power_down && !track_mode)
    else $error("not idle while deselected");
  chk_select_onehot: assert property (@(posedge sys_clk) disable iff (rst) $onehot(input_select))
    else $error("input select not one-hot");
  chk_out_stable_high: assert property (@(posedge sys_clk) disable iff (rst)
    serial_clock && $past(serial_clock) && !frame_select_n && !$past(frame_select_n) |-> $stable(serial_out))
    else $error("serial out moved while clock high");
  chk_leading_zeros: assert property (@(posedge serial_clock) disable iff (rst || frame_select_n) rise_cnt < 4'h4 |-> !serial_out)
    else $error("leading bit not low");
  chk_msb_first: assert property (@(posedge serial_clock) disable iff (rst || frame_select_n)
    rise_cnt == 4'h4 |-> serial_out == conv_result[adc_seq_pkg::RESULT_BITS-1])
    else $error("first result bit wrong");
  chk_powered_in_conv: assert property (@(posedge serial_clock) disable iff (rst || frame_select_n)
    rise_cnt inside {[2:14]} |-> !power_down)
    else $error("powered down mid conversion");
  chk_track_phase: assert property (@(posedge serial_clock) disable iff (rst || frame_select_n)
    (rise_cnt inside {[1:2]} |-> track_mode) and (rise_cnt inside {[4:14]} |-> !track_mode))
    else $error("track phase wrong");
  cov_strobe: cover property (@(posedge sys_clk) sample_strobe);
  cov_last_input: cover property (@(posedge sys_clk) input_select == 4'h8);
  cov_track: cover property (@(posedge sys_clk) $rose(track_mode));
endmodule // adc_seq_monitor
bind quad_channel_adc_serial_sequencer adc_seq_monitor i_mon (.sys_clk(sys_clk), .rst(rst),
  .serial_clock(serial_clock), .frame_select_n(frame_select_n), .serial_out(serial_out),
  .serial_out_en(serial_out_en), .conv_result(conv_result), .input_select(input_select),
  .track_mode(track_mode), .power_down(power_down), .sample_strobe(sample_strobe));

/* sim/host_link_model.sv */
`timescale 1ns/1ns
module host_link_model (
  input wire logic go,
  input wire logic [7:0] ctrl,
  input wire logic serial_out,
  output logic serial_clock,
  output logic frame_select_n,
  output logic serial_in,
  output logic [15:0] rx,
  output logic done
);
  initial begin
    serial_clock = 1'b0;
    frame_select_n = 1'b1;
    serial_in = 1'b0;
    rx = 16'h0000;
    done = 1'b0;
  end
  // one conversion per frame, clock parked low between frames
  always @(posedge go) begin
    #3 frame_select_n = 1'b0;
    for (int k = 0; k < 16; k++) begin
      serial_in = (k < 8) ? ctrl[7 - k] : ~serial_in;
      #32 serial_clock = 1'b1;
      rx = {rx[14:0], serial_out};
      #32;
      if (k == 15) frame_select_n = 1'b1;
      serial_clock = 1'b0;
    end
    serial_in = ~serial_in;
    done = 1'b1;
    #10 done = 1'b0;
  end
endmodule // host_link_model

/* sim/quad_channel_adc_serial_sequencer_bench.sv */
`timescale 1ns/1ns
module quad_channel_adc_serial_sequencer_bench;
  logic sys_clk = 1'b0, rst = 1'b1, go = 1'b0, done, sclk, cs_n, sdi, sdo, sdo_en, trk, pdn, strobe;
  logic [11:0] conv_result = 12'h000, res_v;
  logic [7:0] ctrl = 8'h00, ctrl_v;
  logic [15:0] rx;
  logic [3:0] input_select;
  logic [1:0] chan = 2'h0;
  logic [7:0] words [5] = '{8'hc7, 8'h2f, 8'h10, 8'hd8, 8'h00};
  logic [15:0] word_q [$];
  logic [3:0] sel_q [$];
  int failures = 0, tests_run = 0;
  always #5 sys_clk = ~sys_clk;
  host_link_model i_host (.go(go), .ctrl(ctrl), .serial_out(sdo), .serial_clock(sclk),
    .frame_select_n(cs_n), .serial_in(sdi), .rx(rx), .done(done));
  quad_channel_adc_serial_sequencer i_dut (.sys_clk(sys_clk), .rst(rst), .serial_clock(sclk),
    .frame_select_n(cs_n), .serial_in(sdi), .serial_out(sdo), .serial_out_en(sdo_en),
    .conv_result(conv_result), .input_select(input_select), .track_mode(trk),
    .power_down(pdn), .sample_strobe(strobe));
  task automatic check_word(input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("unexpected word at %0t: exp %h got %h", $time, e, g);
    end
  endtask
  task automatic check_sel(input logic [3:0] e, input logic [3:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("unexpected select at %0t: exp %h got %h", $time, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge done) check_word(word_q.pop_front(), rx);
  always @(negedge sys_clk) if (strobe === 1'b1) check_sel(sel_q.pop_front(), input_select);
  initial begin
    repeat (5000) @(posedge sys_clk);
    failures++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'hfc6c));
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    for (int n = 0; n < 9; n++) begin
      res_v = 12'($urandom);
      ctrl_v = (n < 5) ? words[n] : 8'($urandom);
      word_q.push_back({4'h0, res_v});
      sel_q.push_back(4'h1 << chan);
      conv_result <= res_v;
      ctrl <= ctrl_v;
      go <= 1'b1;
      @(posedge sys_clk);
      go <= 1'b0;
      @(posedge done);
      repeat (3) @(posedge sys_clk);
      chan = ctrl_v[4:3];
    end
    tally_and_finish();
  end
endmodule // quad_channel_adc_serial_sequencer_bench
